// ===== rtl/fpe_regs.vh
`ifndef FPE_REGS_VH
`define FPE_REGS_VH

// control one field positions
`define FPE_C1_PROG 0
`define FPE_C1_ERASE 1
`define FPE_C1_PVER 2
`define FPE_C1_EVER 3
`define FPE_C1_SWE 6
`define FPE_C1_W 8
`define FPE_C1_RESET 8'h00
// control two: error flag position
`define FPE_C2_ERR 7
`define FPE_C2_W 8
`define FPE_C2_RESET 8'h00
// block selects
`define FPE_EB_RESET 8'h00
// programming unit
`define FPE_UNIT_BYTES 128
`define FPE_UNIT_AW 7
`define FPE_ERASED_BYTE 8'hff

`endif

// ===== rtl/fpe_page_buf.v
`default_nettype none
// 128-byte page latch; read data comes out of a register
module fpe_page_buf #(
    parameter DEPTH = 128,
    parameter AW = 7
) (
    input wire sys_clk,
    input wire ce,
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [7:0] wr_data,
    input wire [AW-1:0] rd_idx,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:DEPTH-1];

    // contents need no reset: a fresh unit overwrites every byte
    always @(posedge sys_clk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

// ===== rtl/fpe_err_det.v
`default_nettype none
// error detection: any hazard during an active program/erase
module fpe_err_det (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire busy,
    input wire flash_read,
    input wire exception_taken,
    input wire sleep_exec,
    input wire bus_grant_dma,
    output wire err_event
);
    // combinational so the mode drops on the edge right after the cause
    assign err_event = busy & (flash_read | exception_taken | sleep_exec |
                               bus_grant_dma); // [R14] [R15] [R16] [R17]
endmodule
`default_nettype wire

// ===== rtl/fpe_ctrl.v
// Functional notes
// (R1) Software programs whole 128-byte units, padding unused bytes with ff.
// (R2) Software programs only erased addresses, never reprograms before erase.
// (R3) Device latches program address and 128 consecutive data bytes.
// (R4) Unit start address low byte must be 00 or 80.
// (R5) Programming is applied exactly while program-enable stays set.
// (R6) Verify: dummy write ff to even address, then word reads return data.
// (R7) Software limits program/verify repetitions to characterised count.
// (R8) Erase of selected block lasts exactly while erase-enable stays set.
// (R9) Software selects one block bit; erases blocks one after another.
// (R10) Software repeats erase/verify loop at most characterised count.
// (R11) Reset or standby aborts operations and initialises all four registers.
// (R12) With write-enable clear, enable bits cause no program or erase mode.
// (R13) Unselected blocks are erase-protected; all-zero selects protect all.
// (R14) Flash read during program/erase sets error flag, enters protection.
// (R15) Non-reset exception during program/erase sets error flag.
// (R16) Sleep instruction during program/erase sets error flag.
// (R17) Bus hand-over to DMA during program/erase sets error flag.
// (R18) Error stops mode at once, keeps settings, blocks restart.
// (R19) Verify bits stay settable in error protection.
// (R20) All interrupts including non-maskable blocked while enable bits set.
// (R21) Flash reads during program/erase may return undetermined data.
// (R22) RAM overlay select set protects every block from program/erase.
// (R23) Error flag readable, held until reset or standby.
`include "fpe_regs.vh"
`default_nettype none
module fpe_ctrl #(
    parameter ADDR_W = 24,
    parameter NBLK = 16
) (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire standby,
    // control one write port
    input wire ctl1_wr,
    input wire [7:0] ctl1_wdata,
    // block select writes
    input wire eb1_wr,
    input wire [7:0] eb1_wdata,
    input wire eb2_wr,
    input wire [7:0] eb2_wdata,
    input wire ram_overlay_select_bit,
    // flash area bus accesses
    input wire flash_wr,
    input wire [ADDR_W-1:0] flash_addr,
    input wire [7:0] flash_wdata,
    input wire flash_read,
    input wire exception_taken,
    input wire sleep_exec,
    input wire bus_grant_dma,
    // array side
    input wire [15:0] array_rdata,
    output reg [7:0] flash_control_one,
    output reg [7:0] flash_control_two,
    output reg [7:0] erase_block_select_one,
    output reg [7:0] erase_block_select_two,
    output wire flash_error_flag,
    output reg program_mode,
    output reg erase_mode,
    output reg [NBLK-1:0] erase_blocks,
    output reg program_verify_mode,
    output reg erase_verify_mode,
    output reg [ADDR_W-1:0] latched_addr,
    output reg [ADDR_W-1:0] verify_addr,
    output reg [15:0] verify_rdata,
    output reg read_data_valid,
    output wire [7:0] page_byte,
    input wire [6:0] page_idx,
    output wire irq_block
);
    localparam ST_IDLE = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_FULL = 2'd2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] byte_cnt_r;
    wire clr_all;
    wire err_event;
    wire swe;
    wire pe_bit;
    wire ee_bit;
    wire busy;
    wire allowed;
    wire [15:0] sel;

    // standby acts as a reset of the flash controls
    assign clr_all = rst | standby; // [R11]
    assign swe = flash_control_one[`FPE_C1_SWE];
    assign pe_bit = flash_control_one[`FPE_C1_PROG];
    assign ee_bit = flash_control_one[`FPE_C1_ERASE];
    assign flash_error_flag = flash_control_two[`FPE_C2_ERR]; // [R23]
    assign busy = program_mode | erase_mode;
    assign sel = {erase_block_select_two, erase_block_select_one};
    // mode entry needs write-enable, no overlay and no standing error
    assign allowed = swe & ~ram_overlay_select_bit &
                     ~flash_error_flag; // [R12] [R22] [R18]
    // interrupts held off on the bits, not the modes
    assign irq_block = pe_bit | ee_bit; // [R20]

    fpe_err_det u_err (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .busy(busy),
        .flash_read(flash_read),
        .exception_taken(exception_taken),
        .sleep_exec(sleep_exec),
        .bus_grant_dma(bus_grant_dma),
        .err_event(err_event)
    );

    wire buf_wr;
    assign buf_wr = flash_wr & ~busy & (state_r != ST_FULL);

    fpe_page_buf #(
        .DEPTH(`FPE_UNIT_BYTES),
        .AW(`FPE_UNIT_AW)
    ) u_buf (
        .sys_clk(sys_clk),
        .ce(ce),
        .wr_en(buf_wr),
        .wr_idx(flash_addr[`FPE_UNIT_AW-1:0]),
        .wr_data(flash_wdata),
        .rd_idx(page_idx),
        .rd_data(page_byte)
    );

    // control registers; reset/standby wins over an error flag set and is the only way to clear it
    always @(posedge sys_clk) begin
        if (clr_all) begin
            flash_control_one <= `FPE_C1_RESET; // [R11]
            flash_control_two <= `FPE_C2_RESET;
            erase_block_select_one <= `FPE_EB_RESET;
            erase_block_select_two <= `FPE_EB_RESET;
        end else if (ce) begin
            // verify bits stay writable in error protection
            if (ctl1_wr) begin
                flash_control_one <= ctl1_wdata; // [R19]
            end
            if (eb1_wr) begin
                erase_block_select_one <= eb1_wdata;
            end
            if (eb2_wr) begin
                erase_block_select_two <= eb2_wdata;
            end
            if (err_event) begin
                flash_control_two[`FPE_C2_ERR] <= 1'b1; // [R14] [R23]
            end
        end
    end

    // modes follow their control bits cycle for cycle; error drops program/erase mode now, verify modes stay
    always @(posedge sys_clk) begin
        if (clr_all) begin
            program_mode <= 1'b0;
            erase_mode <= 1'b0;
            erase_blocks <= {NBLK{1'b0}};
            program_verify_mode <= 1'b0;
            erase_verify_mode <= 1'b0;
        end else if (ce) begin
            if (err_event) begin
                program_mode <= 1'b0; // [R18]
                erase_mode <= 1'b0;
                erase_blocks <= {NBLK{1'b0}};
            end else begin
                program_mode <= pe_bit & allowed &
                                (state_r == ST_FULL); // [R5]
                erase_mode <= ee_bit & allowed & (|sel); // [R8] [R13]
                erase_blocks <= (ee_bit & allowed) ?
                                sel[NBLK-1:0] : {NBLK{1'b0}}; // [R13]
            end
            program_verify_mode <= flash_control_one[`FPE_C1_PVER] & swe;
            erase_verify_mode <= flash_control_one[`FPE_C1_EVER] & swe;
        end
    end

    // page load sequencer: first write latches the address
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (buf_wr && !flash_control_one[`FPE_C1_PVER] &&
                    !flash_control_one[`FPE_C1_EVER]) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (buf_wr && byte_cnt_r == `FPE_UNIT_BYTES - 1) begin
                    state_nxt = ST_FULL; // [R3]
                end
            end
            ST_FULL: begin
                // unit consumed when program-enable drops after a pulse
                if (program_mode && !pe_bit) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (clr_all) begin
            state_r <= ST_IDLE;
            byte_cnt_r <= 8'h00;
            latched_addr <= {ADDR_W{1'b0}};
        end else if (ce) begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE && state_nxt == ST_LOAD) begin
                latched_addr <= flash_addr; // [R3]
                byte_cnt_r <= 8'h01;
            end else if (state_r == ST_LOAD && buf_wr) begin
                byte_cnt_r <= byte_cnt_r + 8'h01;
            end
        end
    end

    // verify: dummy ff write to an even address, word read after
    always @(posedge sys_clk) begin
        if (clr_all) begin
            verify_addr <= {ADDR_W{1'b0}};
            verify_rdata <= 16'h0000;
            read_data_valid <= 1'b0;
        end else if (ce) begin
            if (flash_wr && !flash_addr[0] &&
                flash_wdata == `FPE_ERASED_BYTE &&
                (flash_control_one[`FPE_C1_PVER] ||
                 flash_control_one[`FPE_C1_EVER])) begin
                verify_addr <= flash_addr; // [R6]
            end
            verify_rdata <= array_rdata;
            // reads under an active enable bit are flagged unreliable
            read_data_valid <= flash_read & ~irq_block; // [R21]
        end
    end
endmodule
`default_nettype wire

// ===== verification/fpe_ctrl_properties.sv
`default_nettype none
module fpe_ctrl_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic standby,
    input wire logic ctl1_wr,
    input wire logic [7:0] ctl1_wdata,
    input wire logic ram_overlay_select_bit,
    input wire logic flash_read,
    input wire logic exception_taken,
    input wire logic sleep_exec,
    input wire logic bus_grant_dma,
    input wire logic [7:0] flash_control_one,
    input wire logic flash_error_flag,
    input wire logic program_mode,
    input wire logic erase_mode,
    input wire logic irq_block
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // busy drops on the edge after the hazard
    read_err_a: assert property ((program_mode || erase_mode) && flash_read
        && !standby |=> flash_error_flag && !program_mode && !erase_mode)
        else $error("read while busy not flagged");
    exc_err_a: assert property ((program_mode || erase_mode) && !standby
        && exception_taken |=> flash_error_flag) else $error("exception lost");
    sleep_err_a: assert property ((program_mode || erase_mode) && !standby
        && sleep_exec |=> flash_error_flag) else $error("sleep lost");
    dma_err_a: assert property ((program_mode || erase_mode) && !standby
        && bus_grant_dma |=> flash_error_flag) else $error("bus grant lost");
    err_hold_a: assert property (flash_error_flag && !standby
        |=> flash_error_flag) else $error("error flag dropped");
    no_restart_a: assert property ($rose(program_mode) || $rose(erase_mode)
        |-> !$past(flash_error_flag) && !$past(ram_overlay_select_bit))
        else $error("mode entered while protected");
    swe_guard_a: assert property (!flash_control_one[6] [*2]
        |-> !program_mode && !erase_mode) else $error("mode without swe");
    // the bit lands on the edge after the write, the mode one edge later
    prog_end_a: assert property (ctl1_wr && !ctl1_wdata[0]
        |-> ##2 !program_mode) else $error("program outlived its bit");
    erase_end_a: assert property (ctl1_wr && !ctl1_wdata[1]
        |-> ##2 !erase_mode) else $error("erase outlived its bit");
    irq_mask_a: assert property (irq_block ==
        (flash_control_one[0] | flash_control_one[1])) else $error("irq mask");
    standby_a: assert property (standby |=> flash_control_one == 8'h00
        && !flash_error_flag && !program_mode) else $error("standby init");
endmodule
bind fpe_ctrl fpe_ctrl_properties u_props (.sys_clk, .rst, .standby, .ctl1_wr,
    .ctl1_wdata, .ram_overlay_select_bit, .flash_read, .exception_taken,
    .sleep_exec, .bus_grant_dma, .flash_control_one, .flash_error_flag,
    .program_mode, .erase_mode, .irq_block);
`default_nettype wire

// ===== verification/fpe_ctrl_tb.sv
`default_nettype none
module fpe_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, standby = 1'b0;
    logic ctl1_wr = 1'b0, eb1_wr = 1'b0, ovl = 1'b0, flash_wr = 1'b0;
    logic [7:0] ctl1_wdata = 8'h00, eb1_wdata = 8'h00, flash_wdata = 8'h00;
    logic [23:0] flash_addr = 24'h000000;
    logic [3:0] cause = 4'h0; // read, exception, sleep, bus grant
    logic [19:0] rows [8];
    logic [7:0] e, v;
    logic o;
    logic [2:0] x;
    int err_total = 0, samples_checked = 0, cyc = 0;
    wire [7:0] c1;
    wire [23:0] laddr;
    wire [23:0] vaddr;
    wire [15:0] eblk;
    wire err, pm, em, pvm, irq;
    fpe_ctrl dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .standby(standby),
        .ctl1_wr(ctl1_wr), .ctl1_wdata(ctl1_wdata), .eb1_wr(eb1_wr),
        .eb1_wdata(eb1_wdata), .eb2_wr(1'b0), .eb2_wdata(8'h00),
        .ram_overlay_select_bit(ovl), .flash_wr(flash_wr),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_read(cause[0]), .exception_taken(cause[1]),
        .sleep_exec(cause[2]), .bus_grant_dma(cause[3]),
        .array_rdata(16'h0000), .flash_control_one(c1),
        .flash_control_two(), .erase_block_select_one(),
        .erase_block_select_two(), .flash_error_flag(err),
        .program_mode(pm), .erase_mode(em), .erase_blocks(eblk),
        .program_verify_mode(pvm), .erase_verify_mode(),
        .latched_addr(laddr), .verify_addr(vaddr), .verify_rdata(),
        .read_data_valid(), .page_byte(), .page_idx(7'h00),
        .irq_block(irq));
    initial forever #4 sys_clk = ~sys_clk;
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, then settle a cycle before sampling
    task automatic wr1(input logic [7:0] d);
        @(posedge sys_clk);
        ctl1_wr <= 1'b1;
        ctl1_wdata <= d;
        @(posedge sys_clk);
        ctl1_wr <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic blk(input logic [7:0] d, input logic ov);
        @(posedge sys_clk);
        eb1_wr <= 1'b1;
        eb1_wdata <= d;
        ovl <= ov;
        @(posedge sys_clk);
        eb1_wr <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge sys_clk);
        cause <= m;
        @(posedge sys_clk);
        cause <= 4'h0;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic sby();
        @(posedge sys_clk);
        standby <= 1'b1;
        @(posedge sys_clk);
        standby <= 1'b0;
        @(negedge sys_clk);
    endtask
    // whole unit, unused tail padded with erased bytes
    task automatic fill(input logic [23:0] base);
        for (int i = 0; i < 128; i++) begin
            @(posedge sys_clk);
            flash_wr <= 1'b1;
            flash_addr <= base + 24'(i);
            flash_wdata <= (i < 100) ? 8'(i) : 8'hff;
        end
        @(posedge sys_clk);
        flash_wr <= 1'b0;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        // block select, control byte, overlay, expected {pverify, erase, prog}
        rows = '{20'h00411, 20'h00100, 20'h00418, 20'h01422,
                 20'h00420, 20'h01020, 20'h00444, 20'h01428};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            {e, v, o, x} = rows[r];
            blk(e, o);
            // each unit goes to a fresh, aligned, erased area
            if (v[0]) fill(24'h000100 + 24'(r) * 24'h000080);
            if (r == 0) check(laddr, 24'h000100);
            wr1(v);
            check({pvm, em, pm}, x);
            check(irq, v[0] | v[1]);
            check(eblk, {15'h0000, x[1]});
            wr1(8'h40);
            check({pvm, em, pm}, 3'h0);
        end
        blk(8'h00, 1'b0);
        fill(24'h000180);
        wr1(8'h41);
        pulse(4'h1);
        check({err, pm, c1}, {2'b10, 8'h41});
        wr1(8'h41);
        check(pm, 1'b0);
        wr1(8'h44);
        check({err, pvm}, 2'h3);
        // dummy erased-byte write to an even address arms the verify read
        @(posedge sys_clk);
        flash_wr <= 1'b1;
        flash_addr <= 24'h000182;
        flash_wdata <= 8'hff;
        @(posedge sys_clk);
        flash_wr <= 1'b0;
        @(negedge sys_clk);
        check(vaddr, 24'h000182);
        for (int k = 1; k < 4; k++) begin
            sby();
            blk(8'h01, 1'b0);
            wr1(8'h42);
            pulse(4'(1 << k));
            check({err, em}, 2'h2);
        end
        sby();
        check({err, em, c1}, 10'h000);
        end_of_test();
    end
endmodule
`default_nettype wire
